/* File: ecc_cfg_decode.sv */
`default_nettype none

module ecc_cfg_decode (
	ecc_cfg_if.dec cfg // raw bytes in, decoded fields out
);

	function automatic logic [5:0] noise_of(input logic [3:0] c);
		int v;
		v = (int'(c) <= ecc_pkg::ECC_NOISE_KNEE_CODE) ? int'(c) * ecc_pkg::ECC_NOISE_STEP_HDB
			: ecc_pkg::ECC_NOISE_KNEE_HDB
			+ (int'(c) - ecc_pkg::ECC_NOISE_KNEE_CODE - 1) * ecc_pkg::ECC_NOISE_STEP_HDB;
		return 6'(v);
	endfunction

	function automatic logic signed [9:0] adapt_min_level_of(input logic [4:0] c);
		int v;
		v = ecc_pkg::ECC_ADAPT_MIN_LEVEL_BASE_HDB + (int'(c) - 1) * ecc_pkg::ECC_ADAPT_MIN_LEVEL_STEP_HDB;
		return 10'(v);
	endfunction

	function automatic logic [6:0] db3_of(input logic [4:0] c);
		return 7'(int'(c) * ecc_pkg::ECC_DB_STEP);
	endfunction

	wire [3:0] noise_code  = cfg.cfg_a[ecc_pkg::ECC_NOISE_LSB +: 4];
	wire [1:0] fast_code   = cfg.cfg_a[ecc_pkg::ECC_FAST_LSB +: 2];
	wire [1:0] slow_code   = cfg.cfg_a[ecc_pkg::ECC_SLOW_LSB +: 2];
	wire [4:0] byp_code    = cfg.cfg_b[ecc_pkg::ECC_BYP_LSB +: 5];
	wire [1:0] resid_code  = cfg.cfg_b[ecc_pkg::ECC_RESID_LSB +: 2];
	wire [4:0] adapt_min_level_code = cfg.cfg_c[ecc_pkg::ECC_ADAPT_MIN_LEVEL_LSB +: 5];

	// codes 13..15 jump by 3 dB first, then 1.5 dB
	assign cfg.noise_hdb   = noise_of(noise_code);
	// shorter code value means longer period: period = base << (3 - code)
	assign cfg.fast_shift  = 2'b11 - fast_code;
	assign cfg.slow_shift  = 2'b11 - slow_code;
	assign cfg.bypass_db   = db3_of(byp_code);
	assign cfg.resid_db    = 4'(db3_of({3'h0, resid_code}));
	assign cfg.hcd_en      = cfg.cfg_b[ecc_pkg::ECC_HCD_BIT];
	assign cfg.adapt_min_level_none = (adapt_min_level_code == 5'h00);
	assign cfg.adapt_min_level_hdb  = adapt_min_level_of(adapt_min_level_code);
	assign cfg.hang_shift  = cfg.cfg_c[ecc_pkg::ECC_HANG_LSB +: 2];
	assign cfg.dt_std      = cfg.cfg_c[ecc_pkg::ECC_DTSTD_BIT];

endmodule

`default_nettype wire

/* File: ecc_cfg_if.sv */
`default_nettype none

interface ecc_cfg_if;
	logic        [7:0] cfg_a;
	logic        [7:0] cfg_b;
	logic        [7:0] cfg_c;
	logic        [5:0] noise_hdb;
	logic        [1:0] fast_shift;
	logic        [1:0] slow_shift;
	logic        [6:0] bypass_db;
	logic        [3:0] resid_db;
	logic              hcd_en;
	logic              adapt_min_level_none;
	logic signed [9:0] adapt_min_level_hdb;
	logic        [1:0] hang_shift;
	logic              dt_std;

	modport regs (output cfg_a, cfg_b, cfg_c,
		input noise_hdb, fast_shift, slow_shift, bypass_db, resid_db, hcd_en,
		adapt_min_level_none, adapt_min_level_hdb, hang_shift, dt_std);
	modport dec (input cfg_a, cfg_b, cfg_c,
		output noise_hdb, fast_shift, slow_shift, bypass_db, resid_db, hcd_en,
		adapt_min_level_none, adapt_min_level_hdb, hang_shift, dt_std);
endinterface

`default_nettype wire

/* File: ecc_cfg_regs.sv */
// Our own choice: register access over APB.
`default_nettype none

module ecc_cfg_regs #(
	parameter int unsigned FAST_BASE_CYC = ecc_pkg::ECC_FAST_BASE_CYC, // 250 us in cycles
	parameter int unsigned MS_CYC        = ecc_pkg::ECC_MS_CYC         // 1 ms in cycles
) (
	input  wire logic              pclk,                  // bus and block clock
	input  wire logic              presetn,               // async reset, active low
	input  wire logic              psel,                  // apb select
	input  wire logic              penable,               // apb access phase
	input  wire logic              pwrite,                // apb direction
	input  wire logic [7:0]        paddr,                 // apb byte address
	input  wire logic [31:0]       pwdata,                // apb write data
	input  wire logic [3:0]        pstrb,                 // apb byte strobes
	output var  logic [31:0]       prdata,                // apb read data
	output var  logic              pready,                // apb ready
	output var  logic              pslverr,               // apb error
	input  wire logic [7:0]        thl_db,                // measured transhybrid loss, dB
	input  wire logic signed [9:0] send_in_level,         // send-in level, half-dB dBm0
	input  wire logic signed [9:0] receive_in_level,      // receive-in level, half-dB dBm0
	output var  logic [5:0]        noise_margin,          // half-dB units
	output var  logic [31:0]       meter_fast_period,     // cycles
	output var  logic [31:0]       meter_slow_period,     // cycles
	output var  logic [6:0]        bypass_loss_threshold, // dB
	output var  logic              bypass_active,         // canceller bypassed
	output var  logic [3:0]        residual_margin,       // dB
	output var  logic              hybrid_change_detect_en, // hybrid change detect on
	output var  logic              adapt_allowed,         // coefficient adaptation allowed
	output var  logic [31:0]       doubletalk_hangover,   // cycles
	output var  logic              doubletalk_standard_mode, // standard mode selected
	output var  logic              doubletalk_detect_en   // double-talk detection active
);

	ecc_cfg_if cfg ();

	ecc_cfg_decode u_dec (
		.cfg (cfg.dec)
	);

	logic [7:0]  cfg_a_q;
	logic [7:0]  cfg_b_q;
	logic [7:0]  cfg_c_q;
	logic [7:0]  ctrl_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [5:0]  noise_q;
	logic [31:0] fast_q;
	logic [31:0] slow_q;
	logic [6:0]  byp_thr_q;
	logic        bypass_q;
	logic [3:0]  resid_q;
	logic        hcd_q;
	logic        adapt_q;
	logic [31:0] hang_q;
	logic        dt_std_q;
	logic        dt_en_q;

	assign cfg.cfg_a = cfg_a_q;
	assign cfg.cfg_b = cfg_b_q;
	assign cfg.cfg_c = cfg_c_q;

	// bus decode
	wire       setup    = psel & ~penable;
	wire       wr_acc   = psel & penable & pwrite & ~pslverr_q & pstrb[0];
	wire       aligned  = (paddr[1:0] == 2'b00);
	wire [5:0] idx      = paddr[7:2];
	wire       hit_ctrl = aligned & (idx == ecc_pkg::ECC_IDX_CTRL[5:0]);
	wire       hit_stat = aligned & (idx == ecc_pkg::ECC_IDX_STATUS[5:0]);
	wire       hit_a    = aligned & (idx == ecc_pkg::ECC_IDX_CFG_A[5:0]);
	wire       hit_b    = aligned & (idx == ecc_pkg::ECC_IDX_CFG_B[5:0]);
	wire       hit_c    = aligned & (idx == ecc_pkg::ECC_IDX_CFG_C[5:0]);
	wire       hit_cfg  = hit_a | hit_b | hit_c;
	wire       mapped   = hit_ctrl | hit_stat | hit_cfg;
	wire       unlocked = ctrl_q[ecc_pkg::ECC_CTRL_UNLOCK];
	// locked config writes and status writes are refused with an error
	wire       bad_wr   = pwrite & ((hit_cfg & ~unlocked) | hit_stat);
	wire       err_d    = ~mapped | bad_wr;

	wire [7:0] status = {5'h00, adapt_q, dt_en_q, bypass_q};
	wire [7:0] rd_byte = hit_ctrl ? ctrl_q
		: hit_stat ? status
		: hit_a ? cfg_a_q
		: hit_b ? cfg_b_q
		: hit_c ? cfg_c_q : 8'h00;

	// decoded behaviour
	wire       byp_d   = ({1'b0, thl_db} >= {2'b00, cfg.bypass_db});
	wire       lvl_ok  = (send_in_level >= cfg.adapt_min_level_hdb) & (receive_in_level >= cfg.adapt_min_level_hdb);
	wire       adapt_d = cfg.adapt_min_level_none | lvl_ok;
	// standard mode needs at least 6 dB loss; loose mode runs down to 0 dB
	wire       dt_en_d = ~cfg.dt_std | (thl_db >= 8'(ecc_pkg::ECC_DT_STD_MIN_DB));
	wire [31:0] fast_d = FAST_BASE_CYC << cfg.fast_shift;
	wire [31:0] slow_d = (ecc_pkg::ECC_SLOW_MIN_MS * MS_CYC) << cfg.slow_shift;
	wire [31:0] hang_d = (ecc_pkg::ECC_HANG_MIN_MS * MS_CYC) << cfg.hang_shift;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_a_q <= ecc_pkg::ECC_RST_CFG_A;
			cfg_b_q <= ecc_pkg::ECC_RST_CFG_B;
			cfg_c_q <= ecc_pkg::ECC_RST_CFG_C;
			ctrl_q  <= ecc_pkg::ECC_RST_CTRL;
		end else if (wr_acc) begin
			if (hit_ctrl) ctrl_q  <= pwdata[7:0];
			if (hit_a)    cfg_a_q <= pwdata[7:0];
			if (hit_b)    cfg_b_q <= pwdata[7:0];
			if (hit_c)    cfg_c_q <= pwdata[7:0];
		end
	end

	// answer is prepared in the setup cycle so every access phase is zero-wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
			pready_q  <= 1'b0;
		end else begin
			pready_q <= 1'b1;
			if (setup) begin
				prdata_q  <= (pwrite | ~mapped) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
				pslverr_q <= err_d;
			end
		end
	end

	// decoded outputs sit one edge behind their config byte; they read zero in reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			noise_q <= 6'h00;
		end else begin
			noise_q <= cfg.noise_hdb;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_q <= 32'h0000_0000;
		end else begin
			fast_q <= fast_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slow_q <= 32'h0000_0000;
		end else begin
			slow_q <= slow_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byp_thr_q <= 7'h00;
		end else begin
			byp_thr_q <= cfg.bypass_db;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bypass_q <= 1'b0;
		end else begin
			bypass_q <= byp_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resid_q <= 4'h0;
		end else begin
			resid_q <= cfg.resid_db;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hcd_q <= 1'b0;
		end else begin
			hcd_q <= cfg.hcd_en;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adapt_q <= 1'b0;
		end else begin
			adapt_q <= adapt_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hang_q <= 32'h0000_0000;
		end else begin
			hang_q <= hang_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dt_std_q <= 1'b0;
		end else begin
			dt_std_q <= cfg.dt_std;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dt_en_q <= 1'b0;
		end else begin
			dt_en_q <= dt_en_d;
		end
	end

	assign prdata                   = prdata_q;
	assign pready                   = pready_q;
	assign pslverr                  = pslverr_q;
	assign noise_margin             = noise_q;
	assign meter_fast_period        = fast_q;
	assign meter_slow_period        = slow_q;
	assign bypass_loss_threshold    = byp_thr_q;
	assign bypass_active            = bypass_q;
	assign residual_margin          = resid_q;
	assign hybrid_change_detect_en  = hcd_q;
	assign adapt_allowed            = adapt_q;
	assign doubletalk_hangover      = hang_q;
	assign doubletalk_standard_mode = dt_std_q;
	assign doubletalk_detect_en     = dt_en_q;

	noise_top_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_a_q[7:4] == 4'hD) ##1 (cfg_a_q[7:4] == 4'hD) |-> noise_q == 6'd42)
		else $error("noise margin code 13 not 21 dB");

	// sampled presetn keeps the release edge out: outputs load only at the edge after it
	noise_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && cfg_a_q[7:4] == 4'h6) |=> noise_q == 6'd18)
		else $error("noise margin code 6 not 9 dB");

	fast_per_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_a_q[3:2] == 2'b00) |=> fast_q == 32'(FAST_BASE_CYC * 8))
		else $error("fast meter period wrong for 2 ms code");

	slow_per_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_a_q[1:0] == 2'b11) |=> slow_q == 32'(MS_CYC * 8))
		else $error("slow meter period wrong for 8 ms code");

	bypass_cmp_a: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> bypass_q == ($past(thl_db) >= 8'($past(cfg_b_q[7:3]) * 3)))
		else $error("bypass does not follow loss threshold");

	adapt_lvl_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_c_q[7:3] == 5'h01 && send_in_level < -10'sd135) |=> !adapt_q)
		else $error("adaptation allowed below -67.5 dBm0");

	adapt_none_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_c_q[7:3] == 5'h00) |=> adapt_q)
		else $error("adaptation blocked with no minimum level");

	hang_time_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_c_q[2:1] == 2'b11) |=> hang_q == 32'(MS_CYC * 256))
		else $error("hangover not 256 ms");

	dt_loose_a: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && !cfg_c_q[0]) |=> dt_en_q)
		else $error("double-talk off in loose mode");

	dt_std_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_c_q[0] && thl_db < 8'd6) |=> !dt_en_q)
		else $error("double-talk on below 6 dB in standard mode");

	wr_protect_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pwrite && !unlocked) |=> $stable(cfg_a_q) && $stable(cfg_b_q)
		&& $stable(cfg_c_q))
		else $error("config changed while locked");

	resid_mar_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cfg_b_q[2:1] == 2'b01) |=> resid_q == 4'd3)
		else $error("residual margin code 1 not 3 dB");

	hcd_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		presetn |=> hcd_q == $past(cfg_b_q[0]))
		else $error("hybrid change enable not from config bit");

	noise_end_a: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && cfg_a_q[7:4] == 4'hF) |=> noise_q == 6'h30)
		else $error("noise margin code 15 not 24 dB");

	fast_min_a: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && cfg_a_q[3:2] == 2'b11) |=> fast_q == 32'(FAST_BASE_CYC))
		else $error("fast meter period wrong for 250 us code");

	slow_max_a: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && cfg_a_q[1:0] == 2'b00) |=> slow_q == 32'(MS_CYC * 64))
		else $error("slow meter period wrong for 64 ms code");

	byp_top_a: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && cfg_b_q[7:3] == 5'h12) |=> byp_thr_q == 7'h36)
		else $error("bypass threshold code 18 not 54 dB");

	adapt_top_a: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && cfg_c_q[7:3] == 5'h1F && send_in_level >= -10'sh2D
		&& receive_in_level >= -10'sh2D) |=> adapt_q)
		else $error("adaptation blocked at -22.5 dBm0");

	hang_min_a: assert property (@(posedge pclk) disable iff (!presetn)
		(presetn && cfg_c_q[2:1] == 2'b00) |=> hang_q == 32'(MS_CYC * 32))
		else $error("hangover not 32 ms");

	mode_bit_a: assert property (@(posedge pclk) disable iff (!presetn)
		presetn |=> dt_std_q == $past(cfg_c_q[0]))
		else $error("standard mode not from config bit");

	lock_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && pwrite && !unlocked && hit_cfg) |-> pslverr)
		else $error("locked config write not refused");

endmodule

`default_nettype wire

/* File: ecc_host.sv */
`default_nettype none

module ecc_host (
	input  wire logic        pclk,    // bus clock
	input  wire logic [31:0] prdata,  // read data from block
	input  wire logic        pready,  // ready from block
	input  wire logic        pslverr, // error from block
	output var  logic        psel,    // select
	output var  logic        penable, // access phase
	output var  logic        pwrite,  // direction
	output var  logic [7:0]  paddr,   // byte address
	output var  logic [31:0] pwdata,  // write data
	output var  logic [3:0]  pstrb    // byte strobes
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0000_0000;
		pstrb   = 4'h0;
	end

	// one transfer; waits on pready with no assumed wait-state count
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= addr;
		pwdata <= wd;
		pstrb  <= 4'hF;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// released address and data lines must not keep showing the last value
		paddr   <= ~addr;
		pwdata  <= ~wd;
	endtask
endmodule

`default_nettype wire

/* File: ecc_pkg.sv */
`default_nettype none

package ecc_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] ECC_IDX_CTRL   = 8'h00;
	localparam logic [7:0] ECC_IDX_STATUS = 8'h01;
	localparam logic [7:0] ECC_IDX_CFG_A  = 8'h12;
	localparam logic [7:0] ECC_IDX_CFG_B  = 8'h13;
	localparam logic [7:0] ECC_IDX_CFG_C  = 8'h14;

	localparam logic [7:0] ECC_RST_CTRL  = 8'h00;
	localparam logic [7:0] ECC_RST_CFG_A = 8'h69;
	localparam logic [7:0] ECC_RST_CFG_B = 8'h97;
	localparam logic [7:0] ECC_RST_CFG_C = 8'hA4;

	// field positions
	localparam int ECC_CTRL_UNLOCK   = 0;
	localparam int ECC_NOISE_LSB     = 4;
	localparam int ECC_FAST_LSB      = 2;
	localparam int ECC_SLOW_LSB      = 0;
	localparam int ECC_BYP_LSB       = 3;
	localparam int ECC_RESID_LSB     = 1;
	localparam int ECC_HCD_BIT       = 0;
	localparam int ECC_ADAPT_MIN_LEVEL_LSB    = 3;
	localparam int ECC_HANG_LSB      = 1;
	localparam int ECC_DTSTD_BIT     = 0;
	localparam int ECC_ST_BYPASS     = 0;
	localparam int ECC_ST_DT_EN      = 1;
	localparam int ECC_ST_ADAPT      = 2;

	// level and threshold steps; levels are in half-dB units
	localparam int ECC_NOISE_STEP_HDB  = 3;
	localparam int ECC_NOISE_KNEE_CODE = 12;
	localparam int ECC_NOISE_KNEE_HDB  = 42;
	localparam int ECC_DB_STEP         = 3;
	localparam int ECC_ADAPT_MIN_LEVEL_BASE_HDB = -135;
	localparam int ECC_ADAPT_MIN_LEVEL_STEP_HDB = 3;
	localparam int ECC_DT_STD_MIN_DB   = 6;

	// timing
	localparam int ECC_CLK_MHZ      = 200;
	localparam int ECC_FAST_MIN_US  = 250;
	localparam int ECC_MS_US        = 1000;
	localparam int ECC_SLOW_MIN_MS  = 8;
	localparam int ECC_HANG_MIN_MS  = 32;
	localparam int ECC_FAST_BASE_CYC = ECC_FAST_MIN_US * ECC_CLK_MHZ;
	localparam int ECC_MS_CYC        = ECC_MS_US * ECC_CLK_MHZ;

endpackage

`default_nettype wire

/* File: test_echo_control_config_regs.sv */
`default_nettype none

module test_echo_control_config_regs;
	timeunit 1ns;
	timeprecision 1ps;

	logic               pclk;
	logic               presetn;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [7:0]         paddr;
	logic [31:0]        pwdata;
	logic [3:0]         pstrb;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic [7:0]         thl_db;
	logic signed [9:0]  send_in_level;
	logic signed [9:0]  receive_in_level;
	logic [5:0]         noise_margin;
	logic [31:0]        meter_fast_period;
	logic [31:0]        meter_slow_period;
	logic [6:0]         bypass_loss_threshold;
	logic               bypass_active;
	logic [3:0]         residual_margin;
	logic               hybrid_change_detect_en;
	logic               adapt_allowed;
	logic [31:0]        doubletalk_hangover;
	logic               doubletalk_standard_mode;
	logic               doubletalk_detect_en;
	logic [31:0]        rd;
	int                 n_errors;
	int                 checks_done;
	int                 cyc;

	// short counts keep the run small; expectations scale from these
	localparam int FB = 4;
	localparam int MC = 16;

	ecc_cfg_regs #(.FAST_BASE_CYC(FB), .MS_CYC(MC)) i_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .thl_db(thl_db),
		.send_in_level(send_in_level), .receive_in_level(receive_in_level),
		.noise_margin(noise_margin), .meter_fast_period(meter_fast_period),
		.meter_slow_period(meter_slow_period), .bypass_loss_threshold(bypass_loss_threshold),
		.bypass_active(bypass_active), .residual_margin(residual_margin),
		.hybrid_change_detect_en(hybrid_change_detect_en), .adapt_allowed(adapt_allowed),
		.doubletalk_hangover(doubletalk_hangover),
		.doubletalk_standard_mode(doubletalk_standard_mode),
		.doubletalk_detect_en(doubletalk_detect_en));

	ecc_host i_host (.pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb));

	initial pclk = 1'b0;
	always #2.5 pclk = ~pclk;

	task automatic give_verdict();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			n_errors++;
			give_verdict();
		end
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic exp_err);
		logic err;
		i_host.xfer(wr, a, d, rd, err);
		chk("pslverr", {31'h0, err}, {31'h0, exp_err});
	endtask

	task automatic settle();
		repeat (3) @(posedge pclk);
	endtask

	task automatic t_reset();
		logic [7:0] rv [3];
		rv = '{8'h69, 8'h97, 8'hA4};
		for (int i = 0; i < 3; i++) begin
			acc(1'b0, 8'h48 + 8'(4 * i), 32'h0, 1'b0);
			chk("reset value", rd, {24'h0, rv[i]});
		end
		chk("noise at reset", {26'h0, noise_margin}, 32'd18);
		acc(1'b1, 8'h48, 32'h0000_00FF, 1'b1);
		acc(1'b0, 8'h48, 32'h0, 1'b0);
		chk("protected cfg_a", rd, 32'h0000_0069);
		acc(1'b0, 8'h3C, 32'h0, 1'b1);
		acc(1'b1, 8'h00, 32'h0000_0001, 1'b0);
	endtask

	task automatic t_cfg_a();
		for (int c = 0; c < 16; c++) begin
			acc(1'b1, 8'h48, 32'({4'(c), 2'(c), 2'(c)}), 1'b0);
			settle();
			chk("noise", {26'h0, noise_margin}, 32'(c > 12 ? 42 + 3 * (c - 13) : 3 * c));
			chk("fast", meter_fast_period, 32'(FB << (3 - c % 4)));
			chk("slow", meter_slow_period, 32'(8 * MC << (3 - c % 4)));
		end
	endtask

	task automatic t_cfg_b();
		for (int c = 0; c < 32; c++) begin
			acc(1'b1, 8'h4C, 32'({5'(c), 2'(c), 1'(c)}), 1'b0);
			acc(1'b0, 8'h4C, 32'h0, 1'b0);
			chk("cfg_b readback", rd, 32'({5'(c), 2'(c), 1'(c)}));
			thl_db <= 8'(3 * c);
			settle();
			chk("threshold", {25'h0, bypass_loss_threshold}, 32'(3 * c));
			chk("bypass on", {31'h0, bypass_active}, 32'd1);
			chk("resid", {28'h0, residual_margin}, 32'(3 * (c % 4)));
			chk("hcd", {31'h0, hybrid_change_detect_en}, 32'(c % 2));
			if (c > 0) begin
				thl_db <= 8'(3 * c - 1);
				settle();
				chk("bypass off", {31'h0, bypass_active}, 32'd0);
			end
		end
	endtask

	task automatic t_cfg_c();
		int thr;
		for (int k = 0; k < 64; k++) begin
			thr = -135 + 3 * (k / 2 - 1);
			acc(1'b1, 8'h50, 32'({5'(k / 2), 2'(k / 2), 1'(k)}), 1'b0);
			thl_db <= 8'd5;
			send_in_level <= 10'(thr);
			receive_in_level <= 10'(thr);
			settle();
			chk("adapt at level", {31'h0, adapt_allowed}, 32'd1);
			chk("hang", doubletalk_hangover, 32'(32 * MC << (k / 2 % 4)));
			chk("mode", {31'h0, doubletalk_standard_mode}, 32'(k % 2));
			chk("dt below 6", {31'h0, doubletalk_detect_en}, 32'(1 - k % 2));
			thl_db <= 8'd6;
			send_in_level <= 10'(thr - 1);
			settle();
			chk("adapt below", {31'h0, adapt_allowed}, 32'(k < 2));
			chk("dt at 6", {31'h0, doubletalk_detect_en}, 32'd1);
		end
	endtask

	// last scenario leaves code 31, standard mode, loss 6 dB, send level under its floor
	task automatic t_status();
		acc(1'b0, 8'h04, 32'h0, 1'b0);
		chk("status", rd, 32'h0000_0002);
		acc(1'b1, 8'h04, 32'h0000_0007, 1'b1);
	endtask

	initial begin
		n_errors = 0;
		checks_done = 0;
		presetn = 1'b0;
		thl_db = 8'd0;
		send_in_level = 10'sd0;
		receive_in_level = 10'sd0;
		repeat (2) @(posedge pclk);
		chk("pready in reset", {31'h0, pready}, 32'h0);
		presetn <= 1'b1;
		t_reset();
		t_cfg_a();
		t_cfg_b();
		t_cfg_c();
		t_status();
		give_verdict();
	end
endmodule

`default_nettype wire
